// ### core/vid_dispatch.sv
/*
  Vectored interrupt dispatch: arbitration on the dispatch instruction,
  vector table read from program memory, program counter load.
  Assumes the core sequencer pulses dispatchStart for one clk with the
  instruction address, and program memory returns the byte at
  memReq.addr within the same cycle that memReq.rd is high.
  The core gates the global enable before issuing a dispatch and clears
  the trap flag with trapClear; a new trap wins over a clear.
  A start while reading is dropped silently; one in the load cycle is accepted.
  All inputs are from logic on the same clock.
*/
// Overview of operation
// - On dispatch, jump via vector of highest enabled pending source.
// - Table holds up to 16 two-byte vectors at top of the page.
// - Dispatch at a page's last byte uses the next page's table.
// - Dispatch at 00FF to 01FE uses table 01E0 to 01FF, likewise after.
// - Vector is 15 bits, high byte at lower address of the pair.
// - Pairs rise by rank from E0/E1 upward in steps of two, except E2 to F0.
// - Software trap ranks highest, vector always at FE/FF.
// - Rank trap>NMI>pin>idle>capA>capB>shift>twowire>port>default.
// - Two-wire source requests on match, error, nack, stop or data ready.
// - Highest pending goes first; others wait for later dispatches.
// - Nothing active selects the default lowest entry.
// - Even result E0..FE replaces op address low byte; high byte kept, or plus one at FF.
// - Arbitration samples sources in the first dispatch cycle.
// - Maskable source active only with enable and pending set, two-wire also with enable and a condition.
// - Trap occurrence sets a hidden pending flag that wins arbitration.
`timescale 1ns/1ps
`include "vid_regs.svh"

module vid_dispatch
  import vid_pkg::*;
(
  input  wire logic                     clk,            // Core clock
  input  wire logic                     rstn,           // Async reset
  input  wire logic                     dispatchStart,  // Dispatch op, cycle 1
  input  wire logic [`VID_PC_W-1:0]     instrAddr,      // Dispatch op address
  input  wire logic                     trapOpcode,     // Trap op fetched
  input  wire logic                     trapClear,      // Clear trap pending
  input  wire logic [`VID_NSRC-1:0]     srcPending,     // Maskable pending
  input  wire logic [`VID_NSRC-1:0]     srcEnable,      // Maskable enables
  input  wire logic [`VID_NTW-1:0]      twoWireEvents,  // Two-wire conditions
  input  wire logic [7:0]               memData,        // Program memory data
  output vid_pkg::vid_memreq_t          memReq,         // Program memory read
  output vid_pkg::vid_pcload_t          pcLoad,         // PC load to core
  output logic                          busy,           // Dispatch in flight
  output logic                          trapPendingFlag,// Hidden trap flag
  output logic [7:0]                    selOffset       // Last arbitration byte
);
  import vid_pkg::*;

  // Sequencer, trap flag and result registers, each with its next value
  vid_state_t             state_reg, state_next;
  logic                   trap_reg, trap_next;
  logic [`VID_PC_W-1:0]   addr_reg, addr_next;
  logic [6:0]             hiByte_reg, hiByte_next;
  logic [7:0]             ofs_reg, ofs_next;
  logic                   load_reg, load_next;
  logic [`VID_PC_W-1:0]   pc_reg, pc_next;
  logic [`VID_NSRC-1:0]   active;
  logic [`VID_NSRC-1:0]   pendEff;
  logic [7:0]             arbOfs;

  // Rank slot offset of each maskable source, index 0 ranks highest
  function automatic logic [7:0] srcOfs(input int idx);
    case (idx)
      `VID_SRC_NMI:     srcOfs = `VID_OFS_NMI;
      `VID_SRC_EXT:     srcOfs = `VID_OFS_EXT;
      `VID_SRC_IDLE:    srcOfs = `VID_OFS_IDLE;
      `VID_SRC_CAPA:    srcOfs = `VID_OFS_CAPA;
      `VID_SRC_CAPB:    srcOfs = `VID_OFS_CAPB;
      `VID_SRC_SHIFT:   srcOfs = `VID_OFS_SHIFT;
      `VID_SRC_TWOWIRE: srcOfs = `VID_OFS_TWOWIRE;
      `VID_SRC_PORTWK:  srcOfs = `VID_OFS_PORTWK;
      default:          srcOfs = `VID_OFS_DEFAULT;
    endcase
  endfunction

  // Two-wire request is its pending bit ORed with all its conditions
  always_comb begin
    pendEff = srcPending;
    pendEff[`VID_SRC_TWOWIRE] = srcPending[`VID_SRC_TWOWIRE]
                              | (|twoWireEvents);
  end

  // Per-source gate; the core applies the global enable
  genvar g;
  generate
    for (g = 0; g < `VID_NSRC; g++) begin : gActive
      assign active[g] = pendEff[g] & srcEnable[g];
    end
  endgenerate

  // Trap overrides all; else first active by rank; else default slot
  always_comb begin
    arbOfs = `VID_OFS_DEFAULT;
    // Lowest index is visited last, so the highest rank wins
    for (int i = `VID_NSRC - 1; i >= 0; i--) begin
      if (active[i]) begin
        arbOfs = srcOfs(i);
      end
    end
    if (trap_reg) begin
      arbOfs = `VID_OFS_TRAP;
    end
  end

  // Trap flag: a new trap wins over a clear in the same cycle
  always_comb begin
    trap_next = trap_reg;
    if (trapClear) begin
      trap_next = 1'b0;
    end
    if (trapOpcode) begin
      trap_next = 1'b1;
    end
  end

  // Trap flag outlives any one dispatch, so it keeps its own registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trap_reg <= 1'b0;
    end else begin
      trap_reg <= trap_next;
    end
  end

  // Sequencer: accept, read high byte, read low byte
  always_comb begin
    state_next  = state_reg;
    addr_next   = addr_reg;
    hiByte_next = hiByte_reg;
    case (state_reg)
      VID_IDLE: begin
        if (dispatchStart) begin
          // Last byte of a page points the table into the next page
          if (instrAddr[7:0] == `VID_PAGE_LAST) begin
            addr_next = {instrAddr[`VID_PC_W-1:8] + `VID_ONE_PAGE,
                         arbOfs};
          end else begin
            addr_next = {instrAddr[`VID_PC_W-1:8], arbOfs};
          end
          state_next = VID_RDHI;
        end
      end
      VID_RDHI: begin
        // High byte first at the even address, its top bit dropped
        hiByte_next = 7'(memData & `VID_HI_MASK);
        addr_next   = {addr_reg[`VID_PC_W-1:1], 1'b1};
        state_next  = VID_RDLO;
      end
      VID_RDLO: begin
        // Low byte is taken by the result group in this cycle
        state_next = VID_IDLE;
      end
      default: begin
        state_next = VID_IDLE;
      end
    endcase
  end

  // Results to the core: offset on acceptance, target on completion
  always_comb begin
    ofs_next  = ofs_reg;
    load_next = 1'b0;
    pc_next   = pc_reg;
    case (state_reg)
      VID_IDLE: begin
        if (dispatchStart) begin
          // Sources sampled only here, later changes do not matter
          ofs_next = arbOfs;
        end
      end
      VID_RDLO: begin
        pc_next   = {hiByte_reg, memData};
        load_next = 1'b1;
      end
      default: begin
        load_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg  <= VID_IDLE;
      addr_reg   <= '0;
      hiByte_reg <= '0;
    end else begin
      state_reg  <= state_next;
      addr_reg   <= addr_next;
      hiByte_reg <= hiByte_next;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ofs_reg  <= `VID_OFS_DEFAULT;
      load_reg <= 1'b0;
      pc_reg   <= '0;
    end else begin
      ofs_reg  <= ofs_next;
      load_reg <= load_next;
      pc_reg   <= pc_next;
    end
  end

  // Read strobe is decoded from state; the address is a flip-flop
  assign memReq = '{
    rd:   (state_reg == VID_RDHI) || (state_reg == VID_RDLO),
    addr: addr_reg
  };
  assign pcLoad = '{
    load: load_reg,
    pc:   pc_reg
  };
  // Busy spans the load cycle so the core waits for the target
  assign busy            = (state_reg != VID_IDLE) || load_reg;
  assign trapPendingFlag = trap_reg;
  assign selOffset       = ofs_reg;
endmodule

// ### core/vid_pkg.sv
/*
  Types for the vectored interrupt dispatch block.
  Assumes vid_regs.svh is available on the include path.
*/
package vid_pkg;
  `include "vid_regs.svh"
  typedef enum logic [1:0] {VID_IDLE, VID_RDHI, VID_RDLO} vid_state_t;
  // Program memory read request toward the fetch port
  typedef struct packed {
    logic                 rd;
    logic [`VID_PC_W-1:0] addr;
  } vid_memreq_t;
  // Program counter load toward the core sequencer
  typedef struct packed {
    logic                 load;
    logic [`VID_PC_W-1:0] pc;
  } vid_pcload_t;
endpackage

// ### core/vid_regs.svh
/*
  Constants for the vectored interrupt dispatch block: table layout,
  rank slot offsets, widths. Assumes inclusion by core files only.
*/
`ifndef VID_REGS_SVH
`define VID_REGS_SVH
`define VID_PC_W         15
`define VID_PAGE_LAST    8'hFF
`define VID_TABLE_BASE   8'hE0
`define VID_OFS_TRAP     8'hFE
`define VID_OFS_NMI      8'hFC
`define VID_OFS_EXT      8'hFA
`define VID_OFS_IDLE     8'hF8
`define VID_OFS_CAPA     8'hF6
`define VID_OFS_CAPB     8'hF4
`define VID_OFS_SHIFT    8'hF2
`define VID_OFS_TWOWIRE  8'hF0
`define VID_OFS_PORTWK   8'hE2
`define VID_OFS_DEFAULT  8'hE0
`define VID_NSRC         8
`define VID_SRC_NMI      0
`define VID_SRC_EXT      1
`define VID_SRC_IDLE     2
`define VID_SRC_CAPA     3
`define VID_SRC_CAPB     4
`define VID_SRC_SHIFT    5
`define VID_SRC_TWOWIRE  6
`define VID_SRC_PORTWK   7
`define VID_NTW          5
`define VID_HI_MASK      8'h7F
`define VID_ONE_PAGE     7'h01
`endif

// ### dv/vid_dispatch_checker.sv
/* Port assertions for vid_dispatch.
   Assumes binding into vid_dispatch and starts sent only while idle. */
`timescale 1ns/1ps
module vid_dispatch_checker
  import vid_pkg::*;
(
  input wire logic        clk,             // Clock
  input wire logic        rstn,            // Reset
  input wire logic        dispatchStart,   // Start
  input wire logic [14:0] instrAddr,       // Op address
  input wire logic [7:0]  srcPending,      // Pending
  input wire logic [7:0]  srcEnable,       // Enables
  input wire logic [4:0]  twoWireEvents,   // Two-wire
  input wire logic [7:0]  memData,         // Read data
  input vid_pkg::vid_memreq_t memReq,      // Read request
  input vid_pkg::vid_pcload_t pcLoad,      // PC load
  input wire logic        busy,            // Busy
  input wire logic        trapPendingFlag, // Trap flag
  input wire logic [7:0]  selOffset        // Offset
);
  logic [7:0] act;
  logic [7:0] hiByte;
  logic       go;
  logic       quiet;
  assign act = srcPending & srcEnable;
  assign go = dispatchStart && !busy;
  assign quiet = !trapPendingFlag && act == 8'h00
    && !(srcEnable[6] && |twoWireEvents);
  // High byte kept to rebuild the expected PC
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) hiByte <= 8'h00;
    else if (memReq.rd && !memReq.addr[0]) hiByte <= memData;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_page; go |=> memReq.rd && memReq.addr[14:8] ==
    $past(instrAddr[14:8]) + 7'($past(instrAddr[7:0]) == 8'hFF); endproperty
  a_page: assert property (p_page) else $error("page");
  property p_ofs; go |=> memReq.addr[7:0] == selOffset && !selOffset[0]
    && selOffset >= 8'hE0; endproperty
  a_ofs: assert property (p_ofs) else $error("offset");
  property p_trap; go && trapPendingFlag |=> selOffset == 8'hFE; endproperty
  a_trap: assert property (p_trap) else $error("trap");
  property p_none; go && quiet |=> selOffset == 8'hE0; endproperty
  a_none: assert property (p_none) else $error("none");
  property p_ext; go && !trapPendingFlag && act[1:0] == 2'b10
    |=> selOffset == 8'hFA; endproperty
  a_ext: assert property (p_ext) else $error("rank");
  property p_tw; go && !trapPendingFlag && act[5:0] == 6'h00 && srcEnable[6]
    && |twoWireEvents |=> selOffset == 8'hF0; endproperty
  a_tw: assert property (p_tw) else $error("two-wire");
  property p_lo; go |=> ##1 memReq.rd
    && memReq.addr == ($past(memReq.addr) | 15'h0001); endproperty
  a_lo: assert property (p_lo) else $error("low byte");
  property p_load; go |=> ##2 pcLoad.load
    && pcLoad.pc == {hiByte[6:0], $past(memData)}; endproperty
  a_load: assert property (p_load) else $error("load");
  c_trap: cover property (go && trapPendingFlag);
  c_none: cover property (go && quiet);
  c_load: cover property (pcLoad.load);
endmodule

// ### dv/vid_pmem.sv
/* Program memory model serving vector reads.
   Assumes data is taken while rd is high. */
`timescale 1ns/1ps
module vid_pmem
  import vid_pkg::*;
(
  input  vid_pkg::vid_memreq_t memReq,  // Read request
  output logic [7:0]           memData  // Read data
);
  logic [7:0] word;
  // Table bytes have bit 7 set while address bit 14 is clear, so a kept top bit shows up
  assign word = memReq.addr[7:0] ^ {memReq.addr[14:8], 1'b1};
  // Idle bus shows the inverse, never a stale value
  assign memData = memReq.rd ? word : ~word;
endmodule

// ### dv/vid_tb.sv
/* Bench for vid_dispatch: dispatch ops checked for offset and PC.
   Assumes vid_pmem answers table reads. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  n_errors++; $display("Error %s expected %h seen %h", nm, e, g); \
  end end
module tb;
  import vid_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, dispatchStart = 1'b0;
  logic        trapOpcode = 1'b0, trapClear = 1'b0, busy, trapPendingFlag;
  logic [14:0] instrAddr = 15'h0000;
  logic [7:0]  srcPending = 8'h00, srcEnable = 8'h00, memData, selOffset;
  logic [4:0]  twoWireEvents = 5'h00;
  vid_memreq_t memReq;
  vid_pcload_t pcLoad;
  int          n_errors, tests_run, i;
  logic [7:0]  ofs [8] = '{8'hFC, 8'hFA, 8'hF8, 8'hF6, 8'hF4, 8'hF2,
                           8'hF0, 8'hE2};
  vid_dispatch vid_dispatch_i (.clk, .rstn, .dispatchStart, .instrAddr,
    .trapOpcode, .trapClear, .srcPending, .srcEnable, .twoWireEvents,
    .memData, .memReq, .pcLoad, .busy, .trapPendingFlag, .selOffset);
  vid_pmem vid_pmem_i (.memReq, .memData);
  function automatic logic [7:0] memf(input logic [14:0] a);
    return a[7:0] ^ {a[14:8], 1'b1};
  endfunction
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic disp(input logic [14:0] ia, input logic [7:0] pe, en, eo,
                      input logic [4:0] tw);
    logic [14:0] b;
    logic [7:0]  h;
    logic [14:0] p;
    int          k;
    b = {ia[14:8] + 7'(ia[7:0] == 8'hFF), eo};
    h = memf(b);
    p = {h[6:0], memf(b | 15'h0001)};
    @(posedge clk);
    dispatchStart <= 1'b1;
    instrAddr <= ia;
    srcPending <= pe;
    srcEnable <= en;
    twoWireEvents <= tw;
    @(posedge clk);
    dispatchStart <= 1'b0;
    // Sources drop after the first cycle; the choice must not follow
    srcPending <= 8'h00;
    twoWireEvents <= 5'h00;
    for (k = 0; k < 8 && pcLoad.load !== 1'b1; k++) @(negedge clk);
    if (k == 8) begin
      n_errors++;
      give_verdict;
    end
    `CHK("selOffset", eo, selOffset)
    `CHK("memReq.addr", b | 15'h0001, memReq.addr)
    `CHK("pcLoad.pc", p, pcLoad.pc)
    `CHK("busy", 1'b1, busy)
    $display("Dispatch at %h done", ia);
  endtask
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    `CHK("selOffset", 8'hE0, selOffset)
    // Lower ranks stay pending too, so only the top one may win
    for (i = 0; i < 8; i++)
      disp(15'h00FF, 8'hFF << i, 8'hFF, ofs[i], 5'h00);
    disp(15'h01DF, 8'hFF, 8'h00, 8'hE0, 5'h1F);
    for (i = 0; i < 5; i++)
      disp(15'h02FF, 8'h00, 8'h40, 8'hF0, 5'h01 << i);
    @(posedge clk);
    trapOpcode <= 1'b1;
    @(posedge clk);
    trapOpcode <= 1'b0;
    @(negedge clk);
    `CHK("trapPendingFlag", 1'b1, trapPendingFlag)
    disp(15'h0310, 8'hFF, 8'hFF, 8'hFE, 5'h00);
    // Clear alone, then trap and clear together: the trap must win
    @(posedge clk);
    trapClear <= 1'b1;
    @(posedge clk);
    trapOpcode <= 1'b1;
    @(posedge clk);
    trapOpcode <= 1'b0;
    @(negedge clk);
    `CHK("trapPendingFlag", 1'b1, trapPendingFlag)
    @(posedge clk);
    trapClear <= 1'b0;
    @(negedge clk);
    `CHK("trapPendingFlag", 1'b0, trapPendingFlag)
    $display("Trap set and clear done");
    disp(15'h0310, 8'h80, 8'h80, 8'hE2, 5'h00);
    give_verdict;
  end
endmodule
bind vid_dispatch vid_dispatch_checker vid_dispatch_checker_i (.clk, .rstn,
  .dispatchStart, .instrAddr, .srcPending, .srcEnable, .twoWireEvents,
  .memData, .memReq, .pcLoad, .busy, .trapPendingFlag, .selOffset);
